// [aerc_pkg.sv]
package aerc_pkg;

  // Register indices (word addresses)
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_MODE = 2'h2;

  // Mode register field positions
  localparam int MODE_OP_LSB = 13;
  localparam int MODE_UNIPOLAR = 12;
  localparam int MODE_REF_RANGE = 11;
  localparam int MODE_PORT_EN = 10;
  localparam int MODE_PORT4 = 9;
  localparam int MODE_PORT3 = 8;
  localparam int MODE_RANGE_LSB = 4;
  localparam int MODE_BURNOUT = 3;
  localparam int MODE_CHAN_LSB = 0;

  // Status register field positions
  localparam int STAT_READY = 7;
  localparam int STAT_SETTLED = 6;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hFF7F;
  localparam logic [2:0] RANGE_MAX = 3'h6;

  typedef enum logic [2:0] {
    AERC_OP_IDLE = 3'h0,
    AERC_OP_CONT = 3'h1,
    AERC_OP_SINGLE = 3'h2,
    AERC_OP_POWERDOWN = 3'h3,
    AERC_OP_CAL_INT_ZERO = 3'h4,
    AERC_OP_CAL_INT_FULL = 3'h5,
    AERC_OP_CAL_SYS_ZERO = 3'h6,
    AERC_OP_CAL_SYS_FULL = 3'h7
  } aerc_op_e;

  // Calibration lengths in filter output words
  localparam logic [5:0] CAL_WORDS_SHORT = 6'h16;
  localparam logic [5:0] CAL_WORDS_LONG = 6'h2C;

  localparam int ONES_RUN = 32;

endpackage : aerc_pkg

// [aerc_ones_detect.sv]
`timescale 1ns/1ps
module aerc_ones_detect
  import aerc_pkg::*;
#(
  parameter int RUN = ONES_RUN
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic hit
);

  logic [5:0] run_cnt;
  wire last_one = bit_valid && bit_in && (run_cnt == 6'(RUN - 1));

  // Count restarts after a hit so a long run of ones fires once per 32
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_cnt <= 6'h00;
      hit <= 1'b0;
    end else begin
      hit <= last_one;
      if (bit_valid) begin
        run_cnt <= (bit_in && !last_one) ? run_cnt + 6'h01 : 6'h00;
      end
    end
  end

endmodule : aerc_ones_detect

// [aerc_control.sv]
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module aerc_control
  import aerc_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int SETTLE_WORDS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic standby_n,
  input wire logic sync_n,
  input wire logic serial_bit_valid,
  input wire logic serial_bit,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_raw,
  output logic ready_n,
  output logic filter_settled_flag,
  output logic filter_reset,
  output logic analog_power_down,
  output logic serial_reset,
  output logic [2:0] pos_pin_sel,
  output logic [2:0] neg_pin_sel,
  output logic pseudo_diff,
  output logic input_pin_three_out,
  output logic input_pin_three_oe,
  output logic input_pin_four_out,
  output logic input_pin_four_oe,
  output logic unipolar,
  output logic [2:0] gain_stage,
  output logic reference_range_select,
  output logic burnout_enable,
  output logic [2:0] cal_kind,
  output logic cal_active
);

  // Pin pairs per channel code: low three bits positive pin, high three bits negative pin
  function automatic logic [5:0] chan_pins(input logic [2:0] code);
    case (code)
      3'h0: chan_pins = {3'h2, 3'h1};
      3'h1: chan_pins = {3'h4, 3'h3};
      3'h2: chan_pins = {3'h6, 3'h5};
      3'h3: chan_pins = {3'h6, 3'h1};
      3'h4: chan_pins = {3'h6, 3'h2};
      3'h5: chan_pins = {3'h6, 3'h3};
      3'h6: chan_pins = {3'h6, 3'h4};
      default: chan_pins = {3'h6, 3'h5};
    endcase
  endfunction : chan_pins

  // Raw words are two's complement; only the coding differs by polarity
  function automatic logic [DATA_W-1:0] code_word(input logic [DATA_W-1:0] raw,
                                                  input logic uni);
    if (uni) begin
      code_word = raw[DATA_W-1] ? '0 : {raw[DATA_W-2:0], raw[0]};
    end else begin
      code_word = {~raw[DATA_W-1], raw[DATA_W-2:0]};
    end
  endfunction : code_word

  logic [15:0] mode_reg;
  logic [DATA_W-1:0] data_reg;
  logic [3:0] settle_cnt;
  logic [5:0] cal_cnt;
  logic ones_hit;

  aerc_ones_detect #(
    .RUN(ONES_RUN)
  ) u_ones (
    .clk(clk),
    .reset_n(reset_n),
    .bit_valid(serial_bit_valid),
    .bit_in(serial_bit),
    .hit(ones_hit)
  );

  // Event decode
  wire pin_reset = !reset_pin_n;
  wire standby = !standby_n;
  wire sync_ev = !sync_n;
  wire mode_wr = wr && (addr == REG_MODE);
  wire data_rd = rd && (addr == REG_DATA);
  wire [2:0] wr_op = wdata[MODE_OP_LSB +: 3];
  wire [2:0] cur_op = mode_reg[MODE_OP_LSB +: 3];
  wire [2:0] wr_chan = wdata[MODE_CHAN_LSB +: 3];
  wire [2:0] cur_chan = mode_reg[MODE_CHAN_LSB +: 3];
  wire [2:0] wr_range = wdata[MODE_RANGE_LSB +: 3];
  wire wr_idle = mode_wr && (wr_op == AERC_OP_IDLE);
  wire wr_pd = mode_wr && (wr_op == AERC_OP_POWERDOWN);
  wire wr_run = mode_wr && !(wr_op == AERC_OP_IDLE) && !(wr_op == AERC_OP_POWERDOWN);
  wire chan_change = mode_wr && (wr_chan != cur_chan);
  wire filt_rst = pin_reset || standby || sync_ev || wr_idle || wr_pd || wr_run;
  wire flag_set = filt_rst || ones_hit || chan_change;
  wire in_cal = cur_op[2];
  wire [5:0] cal_len = (cur_op == AERC_OP_CAL_INT_FULL) ? CAL_WORDS_LONG : CAL_WORDS_SHORT;
  wire converting = (cur_op == AERC_OP_CONT) || (cur_op == AERC_OP_SINGLE);
  wire word_ok = sample_valid && !flag_set && !standby;
  wire settle_done = settle_cnt >= 4'(SETTLE_WORDS - 1);
  wire cal_end = word_ok && in_cal && (cal_cnt == cal_len - 6'h01);
  wire result_new = word_ok && converting && settle_done;
  // clamp to the seven legal ranges
  wire [2:0] range_in = (wr_range > RANGE_MAX) ? RANGE_MAX : wr_range;
  wire [15:0] mode_wval = {wdata[15:7] & MODE_WMASK[15:7], range_in, wdata[3:0]};
  wire [5:0] pins = chan_pins(mode_reg[MODE_CHAN_LSB +: 3]);
  wire [DATA_W-1:0] status_word = DATA_W'({ready_n, filter_settled_flag, 3'h0, cur_op});
  wire [DATA_W-1:0] mode_word = DATA_W'(mode_reg);
  wire [DATA_W-1:0] rd_mux = (addr == REG_STATUS) ? status_word :
                             (addr == REG_DATA) ? data_reg :
                             (addr == REG_MODE) ? mode_word : '0;

  // Mode register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= MODE_RESET;
    end else if (pin_reset) begin
      mode_reg <= MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= mode_wval;
    end else if (cal_end) begin
      mode_reg[MODE_OP_LSB +: 3] <= AERC_OP_IDLE;
    end
  end

  // Result register; calibration words never reach it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= '0;
    end else if (pin_reset) begin
      data_reg <= '0;
    end else if (result_new) begin
      data_reg <= code_word(sample_raw, mode_reg[MODE_UNIPOLAR]);
    end
  end

  // Settling and calibration word counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 4'h0;
      cal_cnt <= 6'h00;
    end else if (flag_set) begin
      settle_cnt <= 4'h0;
      cal_cnt <= 6'h00;
    end else if (word_ok) begin
      if (!settle_done) begin
        settle_cnt <= settle_cnt + 4'h1;
      end
      cal_cnt <= in_cal ? cal_cnt + 6'h01 : 6'h00;
    end
  end

  // Ready and settled flags; setting always wins over clearing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_n <= 1'b1;
      filter_settled_flag <= 1'b1;
    end else begin
      // ready raised on any flag event
      if (flag_set || data_rd) begin
        ready_n <= 1'b1;
      end else if (result_new || cal_end) begin
        ready_n <= 1'b0;
      end
      if (flag_set) begin
        filter_settled_flag <= 1'b1;
      end else if (word_ok && settle_done) begin
        filter_settled_flag <= 1'b0;
      end
    end
  end

  // Pulses and power state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_reset <= 1'b1;
      analog_power_down <= 1'b1;
      serial_reset <= 1'b1;
      rdata <= '0;
    end else begin
      filter_reset <= filt_rst;
      // analog down only for standby or mode 011
      // Reset pin wins over a same-cycle mode 011 write, which is lost anyway
      analog_power_down <= standby || (!pin_reset && (wr_pd ||
                           (!mode_wr && (cur_op == AERC_OP_POWERDOWN))));
      serial_reset <= pin_reset || ones_hit;
      rdata <= rd ? rd_mux : '0;
    end
  end

  // Configuration outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_pin_sel <= 3'h1;
      neg_pin_sel <= 3'h2;
      pseudo_diff <= 1'b0;
      input_pin_three_out <= 1'b0;
      input_pin_three_oe <= 1'b0;
      input_pin_four_out <= 1'b0;
      input_pin_four_oe <= 1'b0;
      unipolar <= 1'b0;
      gain_stage <= 3'h0;
      reference_range_select <= 1'b0;
      burnout_enable <= 1'b0;
      cal_kind <= 3'h0;
      cal_active <= 1'b0;
    end else begin
      pos_pin_sel <= pins[2:0];
      neg_pin_sel <= pins[5:3];
      pseudo_diff <= cur_chan > 3'h2;
      // digital port on pins three and four
      input_pin_three_out <= mode_reg[MODE_PORT3];
      input_pin_three_oe <= mode_reg[MODE_PORT_EN];
      input_pin_four_out <= mode_reg[MODE_PORT4];
      input_pin_four_oe <= mode_reg[MODE_PORT_EN];
      // polarity feeds coding and calibration points
      unipolar <= mode_reg[MODE_UNIPOLAR];
      gain_stage <= mode_reg[MODE_RANGE_LSB +: 3];
      reference_range_select <= mode_reg[MODE_REF_RANGE];
      burnout_enable <= mode_reg[MODE_BURNOUT];
      cal_kind <= cur_op;
      cal_active <= in_cal && !cal_end && !standby;
    end
  end

endmodule : aerc_control

// [aerc_control_assertions.sv]
`timescale 1ns/1ps
module aerc_control_assertions
  import aerc_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic standby_n,
  input wire logic sync_n,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic ready_n,
  input wire logic filter_settled_flag,
  input wire logic filter_reset,
  input wire logic analog_power_down,
  input wire logic serial_reset,
  input wire logic pseudo_diff,
  input wire logic unipolar,
  input wire logic burnout_enable
);
  logic [15:0] mw1;
  logic [15:0] mw2;
  logic mv1;
  logic mv2;
  wire mode_wr = wr && addr == REG_MODE && reset_pin_n;
  wire quiet = reset_pin_n && !(wr && addr == REG_MODE);
  wire flags = filter_reset && ready_n && filter_settled_flag;
  // Two stages, as config outputs lag the mode register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mv1 <= 1'b0;
      mv2 <= 1'b0;
    end else begin
      mv1 <= mode_wr;
      mv2 <= mv1 && reset_pin_n;
    end
  end
  always_ff @(posedge clk) begin
    mw1 <= wdata;
    mw2 <= mw1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_mwr(logic [2:0] op);
    mode_wr && wdata[15:13] == op;
  endsequence
  property p_mode_flags;
    mode_wr |=> flags;
  endproperty
  a_mode_flags: assert property (p_mode_flags) else $error("mode write flags");
  property p_pd_write;
    s_mwr(3'h3) ##1 quiet |=> analog_power_down;
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("power down write");
  property p_idle_write;
    s_mwr(3'h0) ##1 (quiet && standby_n) |=> !analog_power_down;
  endproperty
  a_idle_write: assert property (p_idle_write) else $error("idle write power");
  property p_pin_reset;
    !reset_pin_n && standby_n |=> flags && serial_reset && !analog_power_down;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin effect");
  property p_standby;
    !standby_n |=> flags && analog_power_down;
  endproperty
  a_standby: assert property (p_standby) else $error("standby effect");
  property p_sync;
    !sync_n |=> flags;
  endproperty
  a_sync: assert property (p_sync) else $error("sync effect");
  property p_data_rd;
    rd && addr == REG_DATA |=> ready_n;
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read ready");
  property p_rdata_idle;
    !rd |=> rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data idle");
  property p_cfg;
    mv2 |-> burnout_enable == mw2[MODE_BURNOUT] && unipolar == mw2[MODE_UNIPOLAR]
      && pseudo_diff == (mw2[2:0] > 3'h2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config fields");
endmodule : aerc_control_assertions

// [aerc_host_model.sv]
`timescale 1ns/1ps
module aerc_host_model (
  input wire logic clk,
  output logic serial_bit_valid,
  output logic serial_bit
);
  initial begin
    serial_bit_valid = 1'b0;
    serial_bit = 1'b0;
  end
  task automatic send(input int n, input logic b, input int gap);
    repeat (n) begin
      @(posedge clk);
      serial_bit_valid <= 1'b1;
      serial_bit <= b;
      @(posedge clk);
      serial_bit_valid <= 1'b0;
      // Idle line never holds a stale bit
      serial_bit <= ~b;
      repeat (gap) @(posedge clk);
    end
  endtask : send
endmodule : aerc_host_model

// [aerc_control_tb_top.sv]
`timescale 1ns/1ps
module aerc_control_tb_top;
  import aerc_pkg::*;
  logic clk, reset_n, reset_pin_n, standby_n, sync_n, serial_bit_valid, serial_bit;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic wr, rd, sample_valid, ready_n, filter_settled_flag, filter_reset;
  logic analog_power_down, serial_reset, pseudo_diff, unipolar, burnout_enable;
  logic reference_range_select, cal_active;
  logic [23:0] sample_raw, rdata, d;
  logic [2:0] pos_pin_sel, neg_pin_sel, gain_stage, cal_kind;
  logic input_pin_three_out, input_pin_three_oe, input_pin_four_out, input_pin_four_oe;
  int mismatches, num_checks, cyc, sr_cnt;
  aerc_control aerc_control_i (.clk, .reset_n, .reset_pin_n, .standby_n, .sync_n,
    .serial_bit_valid, .serial_bit, .addr, .wdata, .wr, .rd, .rdata, .sample_valid,
    .sample_raw, .ready_n, .filter_settled_flag, .filter_reset, .analog_power_down,
    .serial_reset, .pos_pin_sel, .neg_pin_sel, .pseudo_diff, .input_pin_three_out,
    .input_pin_three_oe, .input_pin_four_out, .input_pin_four_oe, .unipolar,
    .gain_stage, .reference_range_select, .burnout_enable, .cal_kind, .cal_active);
  aerc_host_model aerc_host_model_i (.clk, .serial_bit_valid, .serial_bit);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (serial_reset) sr_cnt++;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic smp(input int n, input logic [23:0] v);
    repeat (n) begin
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_raw <= v;
      @(posedge clk);
      sample_valid <= 1'b0;
    end
    #1;
  endtask : smp
  task automatic t_ones();
    sr_cnt = 0;
    aerc_host_model_i.send(31, 1'b1, 0);
    aerc_host_model_i.send(1, 1'b0, 2);
    aerc_host_model_i.send(31, 1'b1, 1);
    repeat (4) @(posedge clk);
    chk("ones short", sr_cnt, 0);
    aerc_host_model_i.send(1, 1'b1, 0);
    repeat (4) @(posedge clk);
    chk("ones hit", sr_cnt, 1);
  endtask : t_ones
  task automatic t_pins();
    wr_reg(REG_MODE, 16'h0F78);
    @(posedge clk);
    #1 chk("port", {input_pin_three_oe, input_pin_three_out, input_pin_four_oe,
      input_pin_four_out, burnout_enable}, 5'h1F);
    chk("range", {reference_range_select, gain_stage}, 4'hE);
    wr_reg(2'h3, 16'hFFFF);
    rd_reg(2'h3);
    chk("unmapped", d, 0);
    @(posedge clk) standby_n <= 1'b0;
    @(posedge clk) standby_n <= 1'b1;
    #1 chk("standby", analog_power_down, 1);
    rd_reg(REG_MODE);
    chk("mode kept", d, 24'h000F68);
    @(posedge clk) sync_n <= 1'b0;
    @(posedge clk) sync_n <= 1'b1;
    #1 chk("sync", {filter_reset, ready_n, analog_power_down}, 3'h6);
    @(posedge clk) reset_pin_n <= 1'b0;
    @(posedge clk) reset_pin_n <= 1'b1;
    #1 chk("pin", {serial_reset, filter_reset, analog_power_down}, 3'h6);
    rd_reg(REG_MODE);
    chk("pin mode", d, 0);
  endtask : t_pins
  task automatic t_ops();
    for (int i = 0; i < 8; i++) begin
      wr_reg(REG_MODE, {i[2:0], 13'h0});
      chk("op flags", {filter_reset, ready_n, filter_settled_flag}, 3'h7);
      @(posedge clk);
      #1 chk("op power", analog_power_down, i == 3);
      if (i > 3) begin
        chk("cal kind", {cal_active, cal_kind}, {1'b1, i[2:0]});
        smp(i == 5 ? 43 : 21, 24'h0);
        chk("cal run", ready_n, 1);
        smp(1, 24'h0);
        chk("cal end", {ready_n, cal_active}, 0);
        rd_reg(REG_STATUS);
        chk("cal status", {d[7], d[2:0]}, 0);
      end
    end
  endtask : t_ops
  task automatic t_conv(input logic uni, input logic [23:0] raw, input logic [23:0] e);
    wr_reg(REG_MODE, {3'h1, uni, 12'h0});
    smp(3, raw);
    chk("settling", ready_n, 1);
    smp(1, raw);
    chk("fresh", {ready_n, filter_settled_flag}, 0);
    rd_reg(REG_DATA);
    chk("coding", d, e);
    chk("read flags", {ready_n, filter_settled_flag}, 2'h2);
    wr_reg(REG_MODE, {3'h1, uni, 12'h3});
    chk("chan ready", ready_n, 1);
    @(posedge clk);
    #1 chk("chan", {pseudo_diff, pos_pin_sel, neg_pin_sel}, 7'h4E);
  endtask : t_conv
  initial begin
    {reset_n, wr, rd, sample_valid, wdata, addr, sample_raw} = '0;
    {reset_pin_n, standby_n, sync_n} = 3'h7;
    repeat (12) @(posedge clk);
    #1 chk("por", {ready_n, filter_settled_flag, filter_reset, analog_power_down,
      serial_reset}, 5'h1F);
    reset_n = 1'b1;
    @(posedge clk);
    #1 chk("por out", {analog_power_down, pos_pin_sel, neg_pin_sel}, 7'h0A);
    t_ones();
    t_pins();
    t_ops();
    t_conv(1'b1, 24'h7FFFFF, 24'hFFFFFF);
    t_conv(1'b0, 24'h7FFFFF, 24'hFFFFFF);
    t_conv(1'b0, 24'h800000, 24'h000000);
    stop_test();
  end
endmodule : aerc_control_tb_top
bind aerc_control aerc_control_assertions #(.DATA_W(DATA_W)) aerc_control_assertions_i (
  .clk, .reset_n, .reset_pin_n, .standby_n, .sync_n, .addr, .wdata, .wr, .rd, .rdata,
  .ready_n, .filter_settled_flag, .filter_reset, .analog_power_down, .serial_reset,
  .pseudo_diff, .unipolar, .burnout_enable);
